// >>> bench/serial_control_register_logic_test.sv
// Purpose: self-checking bench of the serial control block
// Assumes: link clock from the partner model, external 16x source
// Notes:   random data from a fixed seed
`timescale 1ns/1ns
`include "sci_cfg.svh"
`define CHK(nm, exp, got) \
	begin \
		tests_run++; \
		if ((got) !== (exp)) \
		begin \
			error_cnt++; \
			$display("CHECK FAILED %s exp %h got %h", nm, exp, got); \
		end \
	end
module serial_control_register_logic_test;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata, rd;
	logic pready, pslverr, er, rxd, txd, sck_in, sck_out, sck_oe;
	logic tx_empty_irq, rx_full_irq, rx_error_irq, tx_done_irq, irq;
	logic [7:0] b;
	logic [7:0] rb;
	int error_cnt = 0;
	int tests_run = 0;

	always #5 pclk = ~pclk;

	sci_ctrl i_sci_ctrl
	(
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .rxd(rxd), .txd(txd),
		.sck_in(sck_in), .sck_out(sck_out), .sck_oe(sck_oe),
		.tx_empty_irq(tx_empty_irq), .rx_full_irq(rx_full_irq),
		.rx_error_irq(rx_error_irq), .tx_done_irq(tx_done_irq), .irq(irq)
	);

	serial_line_partner i_serial_line_partner
	(
		.rxd(rxd), .sck_in(sck_in), .txd(txd)
	);

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 16);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1)
		begin
			error_cnt++;
			$display("CHECK FAILED pready exp 1 got 0");
			summarize();
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic rg(input logic [7:0] a);
		apb(1'b0, a, 32'h0000_0000);
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge pclk);
	endtask

	task automatic done(input string s);
		$display("test %s ended, mismatches %0d", s, error_cnt);
	endtask

	function automatic logic exp_oe(input logic sync, input logic [1:0] c);
		return sync ? ~c[1] : (c == 2'b01);
	endfunction

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial
	begin
		void'($urandom(32'h456e_d186));
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		rg(`SCI_OFS_CTRL);
		`CHK("ctrl reset", 32'h0000_0000, rd);
		rg(`SCI_OFS_STATUS);
		`CHK("status reset", 32'h0000_0084, rd);
		rg(`SCI_OFS_DIV);
		`CHK("div reset", 32'h0000_0035, rd);
		wr(8'h20, 32'h0000_00ff);
		`CHK("unmapped error", 1'b1, er);
		`CHK("requests idle", 4'h0, {tx_empty_irq, rx_full_irq,
			rx_error_irq, tx_done_irq});
		done("reset");
		// fast oversampling so the bit-rate clock is easy to watch
		wr(`SCI_OFS_DIV, 32'h0000_0000);
		// the old divider count drains before the new one applies
		tick(60);
		for (int m = 0; m < 2; m++)
			for (int c = 0; c < 4; c++)
			begin
				b = (8'($urandom) & 8'h08) | 8'(c);
				wr(`SCI_OFS_MODE, 32'(m));
				wr(`SCI_OFS_CTRL, {24'h0, b});
				rg(`SCI_OFS_CTRL);
				`CHK("ctrl readback", {24'h0, b}, rd);
				tick(3);
				`CHK("pin drive", exp_oe(m[0], b[1:0]), sck_oe);
				if (m == 0 && c == 1)
				begin
					er = sck_out;
					tick(8);
					`CHK("bit rate clock", ~er, sck_out);
				end
			end
		wr(`SCI_OFS_MODE, 32'h0000_0000);
		done("clock pin");
		wr(`SCI_OFS_CTRL, 32'h0000_0084);
		tick(3);
		`CHK("tx empty req", 1'b1, tx_empty_irq);
		`CHK("tx end req", 1'b1, tx_done_irq);
		`CHK("irq masked", 1'b0, irq);
		rg(`SCI_OFS_IRQ_STAT);
		`CHK("irq status", 32'h0000_0009, rd);
		wr(`SCI_OFS_IRQ_MASK, 32'h0000_0001);
		tick(3);
		`CHK("irq unmasked", 1'b1, irq);
		wr(`SCI_OFS_IRQ_STAT, 32'h0000_0009);
		tick(3);
		`CHK("irq cleared", 1'b0, irq);
		wr(`SCI_OFS_CTRL, 32'h0000_0004);
		tick(3);
		`CHK("tx empty off", 1'b0, tx_empty_irq);
		wr(`SCI_OFS_CTRL, 32'h0000_0000);
		tick(3);
		`CHK("tx end off", 1'b0, tx_done_irq);
		rg(`SCI_OFS_STATUS);
		wr(`SCI_OFS_STATUS, 32'h0000_0000);
		rg(`SCI_OFS_STATUS);
		`CHK("empty held", 1'b1, rd[7]);
		done("interrupts");
		// transmit on the external 16x clock, even parity
		b = 8'($urandom);
		wr(`SCI_OFS_MODE, 32'h0000_0002);
		wr(`SCI_OFS_CTRL, 32'h0000_0026);
		wr(`SCI_OFS_TXDATA, {24'h0, b});
		rg(`SCI_OFS_STATUS);
		wr(`SCI_OFS_STATUS, 32'h0000_0000);
		i_serial_line_partner.frame(8'hff, 1'b1, 13);
		`CHK("sent byte", b, i_serial_line_partner.got);
		rg(`SCI_OFS_STATUS);
		`CHK("tx end status", 32'h0000_0084, rd);
		`CHK("tx end req", 1'b1, tx_done_irq);
		wr(`SCI_OFS_STATUS, 32'h0000_0000);
		tick(3);
		`CHK("tx end cleared", 1'b0, tx_done_irq);
		wr(`SCI_OFS_CTRL, 32'h0000_0000);
		done("transmit");
		// receive, then a bad stop bit on top of a full buffer
		wr(`SCI_OFS_MODE, 32'h0000_0000);
		wr(`SCI_OFS_CTRL, 32'h0000_0052);
		b = 8'($urandom);
		i_serial_line_partner.frame(b, 1'b1, 11);
		tick(3);
		`CHK("rx full req", 1'b1, rx_full_irq);
		`CHK("rx error quiet", 1'b0, rx_error_irq);
		rg(`SCI_OFS_RXDATA);
		`CHK("rx byte", {24'h0, b}, rd);
		i_serial_line_partner.frame(8'($urandom), 1'b0, 11);
		tick(3);
		`CHK("rx error req", 1'b1, rx_error_irq);
		wr(`SCI_OFS_CTRL, 32'h0000_0002);
		tick(3);
		`CHK("rx reqs off", 2'b00, {rx_full_irq, rx_error_irq});
		rg(`SCI_OFS_STATUS);
		`CHK("rx flags kept", 2'b11, {rd[6], |rd[5:3]});
		wr(`SCI_OFS_CTRL, 32'h0000_0042);
		tick(3);
		`CHK("rx full again", 1'b1, rx_full_irq);
		wr(`SCI_OFS_STATUS, 32'h0000_0000);
		tick(3);
		`CHK("rx reqs cleared", 2'b00, {rx_full_irq, rx_error_irq});
		done("receive");
		// clocked synchronous, both ways on the far party's clock
		wr(`SCI_OFS_MODE, 32'h0000_0001);
		wr(`SCI_OFS_CTRL, 32'h0000_0072);
		b = 8'($urandom);
		rb = 8'($urandom);
		wr(`SCI_OFS_TXDATA, {24'h0, b});
		rg(`SCI_OFS_STATUS);
		wr(`SCI_OFS_STATUS, 32'h0000_0000);
		i_serial_line_partner.sync_frame(rb);
		`CHK("sync sent", b, i_serial_line_partner.sgot);
		rg(`SCI_OFS_RXDATA);
		`CHK("sync rx byte", {24'h0, rb}, rd);
		done("sync");
		summarize();
	end
endmodule

// >>> bench/serial_line_partner.sv
// Purpose: remote serial device on the far side of the line
// Assumes: it supplies the link clock, 16 edges per bit in frame, one per bit in sync_frame, 80 ns period
// Notes:   link clock stands still between frames
`timescale 1ns/1ns
module serial_line_partner
(
	output logic rxd,
	output logic sck_in,
	input wire logic txd
);
	logic [7:0] got;
	logic [7:0] sgot;
	int cnt;

	initial
	begin
		rxd = 1'b1;
		sck_in = 1'b0;
		got = 8'h00;
		cnt = 0;
	end

	// ----------------------------------------
	// frame sender
	// ----------------------------------------
	// bits past the stop bit are idle high, so the link clock keeps running
	// long enough for the device's own frame to finish
	task automatic frame(input logic [7:0] b, input logic stop,
		input int nbits);
		logic [9:0] f;
		f = {stop, b, 1'b0};
		for (int i = 0; i < nbits; i++)
		begin
			rxd = (i < 10) ? f[i] : 1'b1;
			repeat (16)
			begin
				#40 sck_in = 1'b1;
				#40 sck_in = 1'b0;
			end
		end
		rxd = 1'b1;
	endtask

	// ----------------------------------------
	// clocked synchronous exchange
	// ----------------------------------------
	// device shifts out on the fall, so its bit is read at the next rise;
	// a ninth clock lets the device close its frame
	task automatic sync_frame(input logic [7:0] b);
		for (int i = 0; i < 9; i++)
		begin
			rxd = (i < 8) ? b[i] : 1'b1;
			#40 sck_in = 1'b1;
			if (i > 0)
				sgot = {txd, sgot[7:1]};
			#40 sck_in = 1'b0;
		end
		rxd = 1'b1;
	endtask

	// ----------------------------------------
	// line capture
	// ----------------------------------------
	// sample mid-bit on our own edges; device lags a few pclk behind
	always @(posedge sck_in)
	begin
		if (cnt == 0)
		begin
			if (txd === 1'b0)
				cnt = 1;
		end
		else
		begin
			cnt = cnt + 1;
			if (cnt > 8 && cnt < 150 && cnt % 16 == 8)
				got = {txd, got[7:1]};
			if (cnt == 168)
				cnt = 0;
		end
	end
endmodule

// >>> rtl/pin_sync.sv
// Purpose: two-flop synchroniser with edge pulses for pin inputs
// Assumes: inputs asynchronous to pclk
// Notes:   stage one feeds stage two only
`timescale 1ns/1ns
module pin_sync
#(
	parameter int W = 2
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q,
	output logic [W-1:0] rise,
	output logic [W-1:0] fall
);

	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
	} sync_t;

	sync_t r_reg;
	sync_t r_next;

	if (W < 1)
	begin : bad_width
		$error("pin_sync width below one");
	end

	always_comb
	begin
		r_next.s1 = d;
		r_next.s2 = r_reg.s1;
		r_next.s3 = r_reg.s2;
	end

	// idle-high reset keeps a false rising edge away at release
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			r_reg <= '1;
		else
			r_reg <= r_next;
	end

	for (genvar i = 0; i < W; i++)
	begin : g_bit
		assign q[i] = r_reg.s2[i];
		assign rise[i] = r_reg.s2[i] & ~r_reg.s3[i];
		assign fall[i] = ~r_reg.s2[i] & r_reg.s3[i];
	end

endmodule

// >>> rtl/sci_cfg.svh
// Purpose: offsets, field positions, reset values and counts of the
//          serial control block
// Assumes: APB byte addresses, one 32-bit word per register
// Notes:   definitions only
`ifndef SCI_CFG_SVH
`define SCI_CFG_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define SCI_OFS_CTRL 8'h00
`define SCI_OFS_STATUS 8'h04
`define SCI_OFS_TXDATA 8'h08
`define SCI_OFS_RXDATA 8'h0c
`define SCI_OFS_MODE 8'h10
`define SCI_OFS_DIV 8'h14
`define SCI_OFS_IRQ_STAT 8'h18
`define SCI_OFS_IRQ_MASK 8'h1c

// ----------------------------------------
// fields
// ----------------------------------------
`define SCI_ST_LSB 2
`define SCI_ST_MSB 7
`define SCI_IRQ_TXE 0
`define SCI_IRQ_RXF 1
`define SCI_IRQ_RXE 2
`define SCI_IRQ_TXD 3

// ----------------------------------------
// reset values
// ----------------------------------------
`define SCI_CTRL_RST 8'h00
`define SCI_MODE_RST 2'h0
`define SCI_DIV_RST 16'h0035
`define SCI_FLAGS_RST 6'h21

// ----------------------------------------
// timing counts
// ----------------------------------------
`define SCI_OS_LAST 4'hf
`define SCI_OS_MID 4'h7
`define SCI_SYNC_BITS 4'h8
`define SCI_ASYNC_BITS 4'ha
`define SCI_ASYNC_PBITS 4'hb

`endif

// >>> rtl/sci_ctrl.sv
// Purpose: serial control register and its transmit, receive and
//          clock-pin logic behind an APB slave
// Assumes: pclk 100 MHz, pins asynchronous to pclk
// Notes:   one wait state on every APB access
`timescale 1ns/1ns
`include "sci_cfg.svh"

module sci_ctrl
	import sci_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic rxd,
	output logic txd,
	input wire logic sck_in,
	output logic sck_out,
	output logic sck_oe,
	output logic tx_empty_irq,
	output logic rx_full_irq,
	output logic rx_error_irq,
	output logic tx_done_irq,
	output logic irq
);

	localparam core_t CORE_RST = '{
		ctrl: `SCI_CTRL_RST,
		mode: `SCI_MODE_RST,
		div: `SCI_DIV_RST,
		flags: `SCI_FLAGS_RST,
		sck_lvl: 1'b1,
		txd: 1'b1,
		tx_st: TX_IDLE,
		rx_st: RX_IDLE,
		default: '0
	};

	core_t s_reg;
	core_t s_next;
	logic [1:0] pin_q;
	logic [1:0] pin_rise;
	logic [1:0] pin_fall;
	logic acc;
	logic wr;
	logic rd;
	logic ext;
	logic sync;
	logic baud_tick;
	logic os_tick;
	logic run;
	logic sck_r;
	logic sck_f;
	logic tx_step;
	logic rx_bit;
	logic rx_done;
	logic rx_stop;
	logic [3:0] req;
	logic [5:0] clr;
	logic [3:0] rx_last;

	// ----------------------------------------
	// pin synchronisers: [0] receive data, [1] clock pin
	// ----------------------------------------
	pin_sync #(.W(2)) u_pins (
		.pclk(pclk),
		.presetn(presetn),
		.d({sck_in, rxd}),
		.q(pin_q),
		.rise(pin_rise),
		.fall(pin_fall)
	);

	// ----------------------------------------
	// timing terms
	// ----------------------------------------
	assign acc = psel & penable & s_reg.pready;
	assign wr = acc & pwrite;
	assign rd = acc & ~pwrite;
	assign ext = s_reg.ctrl.cke[1];
	assign sync = s_reg.mode.sync;
	assign baud_tick = (s_reg.baud_cnt == 16'h0000);
	assign os_tick = ext ? pin_rise[1] : baud_tick;
	// internal clock only runs while there is something to move
	assign run = (s_reg.tx_st == TX_SHIFT) | s_reg.ctrl.re;
	assign sck_r = sync & (ext ? pin_rise[1] :
		baud_tick & ~s_reg.sck_lvl & run);
	assign sck_f = sync & (ext ? pin_fall[1] :
		baud_tick & s_reg.sck_lvl & run);
	assign tx_step = sync ? sck_f :
		(os_tick & (s_reg.os_cnt == `SCI_OS_LAST));
	assign rx_bit = os_tick & (s_reg.rx_os == `SCI_OS_MID);
	assign rx_last = s_reg.mode.par_en ? 4'ha : 4'h9;
	assign req[`SCI_IRQ_TXE] = s_reg.flags.tx_buf_empty_flag & s_reg.ctrl.tx_empty_irq_en;
	assign req[`SCI_IRQ_RXF] = s_reg.flags.rx_buf_full_flag & s_reg.ctrl.rx_irq_en;
	assign req[`SCI_IRQ_RXE] = (s_reg.flags.framing_error_flag | s_reg.flags.parity_error_flag |
		s_reg.flags.overrun_flag) & s_reg.ctrl.rx_irq_en;
	assign req[`SCI_IRQ_TXD] = s_reg.flags.tx_complete_flag & s_reg.ctrl.tx_done_irq_en;
	// a flag clears on a written zero only after it was read as one
	assign clr = ~pwdata[`SCI_ST_MSB:`SCI_ST_LSB] & s_reg.seen;

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb
	begin
		s_next = s_reg;
		rx_done = 1'b0;
		rx_stop = 1'b1;
		s_next.pready = psel & penable & ~s_reg.pready;
		s_next.pslverr = 1'b0;
		s_next.prdata = 32'h0000_0000;
		if (s_next.pready)
		begin
			unique case (paddr)
				`SCI_OFS_CTRL: s_next.prdata[7:0] = s_reg.ctrl;
				`SCI_OFS_STATUS:
					s_next.prdata[`SCI_ST_MSB:`SCI_ST_LSB] = s_reg.flags;
				`SCI_OFS_TXDATA: s_next.prdata[7:0] = s_reg.tx_data_reg;
				`SCI_OFS_RXDATA: s_next.prdata[7:0] = s_reg.rdr;
				`SCI_OFS_MODE: s_next.prdata[1:0] = s_reg.mode;
				`SCI_OFS_DIV: s_next.prdata[15:0] = s_reg.div;
				`SCI_OFS_IRQ_STAT: s_next.prdata[3:0] = s_reg.irq_stat;
				`SCI_OFS_IRQ_MASK: s_next.prdata[3:0] = s_reg.irq_mask;
				default: s_next.pslverr = 1'b1;
			endcase
		end
		if (rd && paddr == `SCI_OFS_STATUS)
			s_next.seen = s_reg.seen |
				s_reg.prdata[`SCI_ST_MSB:`SCI_ST_LSB];
		if (wr)
		begin
			unique case (paddr)
				`SCI_OFS_CTRL: s_next.ctrl = pwdata[7:0];
				`SCI_OFS_STATUS:
				begin
					s_next.flags = s_reg.flags & ~clr;
					s_next.seen = s_reg.seen & ~clr;
				end
				`SCI_OFS_TXDATA: s_next.tx_data_reg = pwdata[7:0];
				`SCI_OFS_MODE: s_next.mode = pwdata[1:0];
				`SCI_OFS_DIV: s_next.div = pwdata[15:0];
				`SCI_OFS_IRQ_STAT:
					s_next.irq_stat = s_reg.irq_stat & ~pwdata[3:0];
				`SCI_OFS_IRQ_MASK: s_next.irq_mask = pwdata[3:0];
				default: s_next.pslverr = 1'b0;
			endcase
		end

		s_next.baud_cnt = baud_tick ? s_reg.div : s_reg.baud_cnt - 16'h0001;
		if (!sync && os_tick)
			s_next.os_cnt = s_reg.os_cnt + 4'h1;
		if (sck_r)
			s_next.sck_lvl = 1'b1;
		else if (sck_f)
			s_next.sck_lvl = 1'b0;

		// transmit: hardware sets follow software clears, so set wins
		unique case (s_reg.tx_st)
			TX_IDLE:
				if (s_reg.ctrl.te && !s_reg.flags.tx_buf_empty_flag)
				begin
					s_next.tx_st = TX_SHIFT;
					s_next.flags.tx_buf_empty_flag = 1'b1;
					s_next.flags.tx_complete_flag = 1'b0;
					if (sync)
					begin
						s_next.tx_sh = {3'b111, s_reg.tx_data_reg};
						s_next.tx_cnt = `SCI_SYNC_BITS;
					end
					else
					begin
						// without parity the stop bit takes the parity slot
						s_next.tx_sh = {1'b1,
							s_reg.mode.par_en ? ^s_reg.tx_data_reg : 1'b1,
							s_reg.tx_data_reg, 1'b0};
						s_next.tx_cnt = s_reg.mode.par_en ?
							`SCI_ASYNC_PBITS : `SCI_ASYNC_BITS;
					end
				end
			TX_SHIFT:
				if (tx_step)
				begin
					if (s_reg.tx_cnt == 4'h0)
					begin
						s_next.tx_st = TX_IDLE;
						s_next.txd = 1'b1;
						s_next.flags.tx_complete_flag = s_next.flags.tx_buf_empty_flag;
					end
					else
					begin
						s_next.txd = s_reg.tx_sh[0];
						s_next.tx_sh = {1'b1, s_reg.tx_sh[10:1]};
						s_next.tx_cnt = s_reg.tx_cnt - 4'h1;
					end
				end
		endcase
		if (!s_reg.ctrl.te)
		begin
			s_next.tx_st = TX_IDLE;
			s_next.txd = 1'b1;
			s_next.flags.tx_buf_empty_flag = 1'b1;
		end

		// receive
		unique case (s_reg.rx_st)
			RX_IDLE:
				if (sync && sck_r)
				begin
					s_next.rx_st = RX_SHIFT;
					s_next.rx_sh = {pin_q[0], s_reg.rx_sh[7:1]};
					s_next.rx_cnt = 4'h1;
				end
				else if (!sync && os_tick && !pin_q[0])
				begin
					s_next.rx_st = RX_SHIFT;
					s_next.rx_os = 4'h0;
					s_next.rx_cnt = 4'h0;
				end
			RX_SHIFT:
				if (sync)
				begin
					if (sck_r)
					begin
						s_next.rx_sh = {pin_q[0], s_reg.rx_sh[7:1]};
						s_next.rx_cnt = s_reg.rx_cnt + 4'h1;
						rx_done = (s_reg.rx_cnt == 4'h7);
					end
				end
				else
				begin
					if (os_tick)
						s_next.rx_os = s_reg.rx_os + 4'h1;
					if (rx_bit)
					begin
						s_next.rx_cnt = s_reg.rx_cnt + 4'h1;
						if (s_reg.rx_cnt == 4'h0 && pin_q[0])
							s_next.rx_st = RX_IDLE;
						else if (s_reg.rx_cnt == rx_last)
						begin
							rx_done = 1'b1;
							rx_stop = pin_q[0];
						end
						else if (s_reg.rx_cnt == 4'h9)
							s_next.rx_par = pin_q[0];
						else if (s_reg.rx_cnt != 4'h0)
							s_next.rx_sh = {pin_q[0], s_reg.rx_sh[7:1]};
					end
				end
		endcase
		// a frame ending just as receive goes off must not touch flags
		if (rx_done && s_reg.ctrl.re)
		begin
			s_next.rx_st = RX_IDLE;
			if (s_reg.flags.rx_buf_full_flag)
				s_next.flags.overrun_flag = 1'b1;
			else
			begin
				s_next.rdr = s_next.rx_sh;
				s_next.flags.rx_buf_full_flag = 1'b1;
				s_next.flags.framing_error_flag = ~rx_stop;
				s_next.flags.parity_error_flag = s_reg.mode.par_en & ~sync &
					(^s_next.rx_sh ^ s_reg.rx_par);
			end
		end
		// flags are left alone here, only the engine stops
		if (!s_reg.ctrl.re)
			s_next.rx_st = RX_IDLE;

		// clock pin direction and level
		s_next.sck_oe = sync ? ~ext : (s_reg.ctrl.cke == 2'b01);
		s_next.sck_out = sync ? s_reg.sck_lvl : s_reg.os_cnt[3];

		// interrupts: request lines and sticky summary
		s_next.irq_req = req;
		s_next.irq_stat = s_next.irq_stat | (req & ~s_reg.irq_req);
		s_next.irq = |(s_reg.irq_stat & s_reg.irq_mask);
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			s_reg <= CORE_RST;
		else
			s_reg <= s_next;
	end

	assign prdata = s_reg.prdata;
	assign pready = s_reg.pready;
	assign pslverr = s_reg.pslverr;
	assign txd = s_reg.txd;
	assign sck_out = s_reg.sck_out;
	assign sck_oe = s_reg.sck_oe;
	assign tx_empty_irq = s_reg.irq_req[`SCI_IRQ_TXE];
	assign rx_full_irq = s_reg.irq_req[`SCI_IRQ_RXF];
	assign rx_error_irq = s_reg.irq_req[`SCI_IRQ_RXE];
	assign tx_done_irq = s_reg.irq_req[`SCI_IRQ_TXD];
	assign irq = s_reg.irq;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	logic st_wr;
	assign st_wr = wr & (paddr == `SCI_OFS_STATUS);

	tx_done_gate_a: assert property (
		!s_reg.ctrl.tx_done_irq_en |=> !tx_done_irq)
		else $error("transmit-end request without enable");
	tx_done_end_a: assert property (
		(!s_reg.flags.tx_complete_flag || !s_reg.ctrl.tx_done_irq_en) |=> !tx_done_irq)
		else $error("transmit-end request outlived its cause");
	async_pin_free_a: assert property (
		(!sync && s_reg.ctrl.cke == 2'b00) |=> !sck_oe)
		else $error("clock pin driven with select 00");
	async_clk_out_a: assert property (
		(!sync && s_reg.ctrl.cke == 2'b01) |=> sck_oe)
		else $error("bit-rate clock not driven with select 01");
	async_ext_clk_a: assert property (
		(!sync && ext) |=> !sck_oe ##0
		(s_reg.os_cnt == $past(s_reg.os_cnt) + $past({3'b000, pin_rise[1]})))
		else $error("external oversample clock misused");
	sync_int_clk_a: assert property (
		(sync && !ext) |=> sck_oe)
		else $error("internal sync clock not driven out");
	sync_ext_clk_a: assert property (
		(sync && ext) |=> !sck_oe)
		else $error("clock pin driven with external sync clock");
	tx_empty_gate_a: assert property (
		!s_reg.ctrl.tx_empty_irq_en |=> !tx_empty_irq)
		else $error("transmit-empty request without enable");
	tx_empty_end_a: assert property (
		(!s_reg.flags.tx_buf_empty_flag || !s_reg.ctrl.tx_empty_irq_en) |=> !tx_empty_irq)
		else $error("transmit-empty request outlived its cause");
	rx_gate_a: assert property (
		!s_reg.ctrl.rx_irq_en |=> !rx_full_irq && !rx_error_irq)
		else $error("receive request without enable");
	tx_start_a: assert property (
		(s_reg.ctrl.te && !s_reg.flags.tx_buf_empty_flag && s_reg.tx_st == TX_IDLE)
		|=> s_reg.tx_st == TX_SHIFT && s_reg.flags.tx_buf_empty_flag)
		else $error("frame did not start");
	tx_halt_a: assert property (
		!s_reg.ctrl.te |=> s_reg.flags.tx_buf_empty_flag && txd &&
		s_reg.tx_st == TX_IDLE)
		else $error("transmit not halted");
	rx_start_a: assert property (
		(s_reg.ctrl.re && sync && sck_r && s_reg.rx_st == RX_IDLE)
		|=> s_reg.rx_st == RX_SHIFT)
		else $error("reception did not start on clock");
	rx_flags_hold_a: assert property (
		(!s_reg.ctrl.re && !st_wr) |=>
		s_reg.flags[4:1] == $past(s_reg.flags[4:1]))
		else $error("receive flags moved with receive off");

	async_frame_c: cover property (
		!sync && s_reg.ctrl.te && s_reg.tx_st == TX_SHIFT ##1
		s_reg.tx_st == TX_IDLE && s_reg.flags.tx_complete_flag);
	rx_overrun_c: cover property ($rose(s_reg.flags.overrun_flag));
	sync_ext_rx_c: cover property (sync && ext && rx_done);

endmodule

// >>> rtl/sci_pkg.sv
// Purpose: types of the serial control block
// Assumes: nothing
// Notes:   constants live in sci_cfg.svh
package sci_pkg;

	typedef struct packed {
		logic tx_empty_irq_en;
		logic rx_irq_en;
		logic te;
		logic re;
		logic mpie;
		logic tx_done_irq_en;
		logic [1:0] cke;
	} ctrl_t;

	typedef struct packed {
		logic tx_buf_empty_flag;
		logic rx_buf_full_flag;
		logic overrun_flag;
		logic framing_error_flag;
		logic parity_error_flag;
		logic tx_complete_flag;
	} flags_t;

	typedef struct packed {
		logic par_en;
		logic sync;
	} mode_t;

	typedef enum logic {TX_IDLE, TX_SHIFT} tx_state_t;
	typedef enum logic {RX_IDLE, RX_SHIFT} rx_state_t;

	typedef struct packed {
		ctrl_t ctrl;
		mode_t mode;
		logic [15:0] div;
		logic [15:0] baud_cnt;
		logic [7:0] tx_data_reg;
		logic [7:0] rdr;
		flags_t flags;
		logic [5:0] seen;
		logic [3:0] os_cnt;
		logic sck_lvl;
		tx_state_t tx_st;
		logic [10:0] tx_sh;
		logic [3:0] tx_cnt;
		rx_state_t rx_st;
		logic [7:0] rx_sh;
		logic rx_par;
		logic [3:0] rx_os;
		logic [3:0] rx_cnt;
		logic [3:0] irq_stat;
		logic [3:0] irq_mask;
		logic [3:0] irq_req;
		logic irq;
		logic txd;
		logic sck_out;
		logic sck_oe;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} core_t;

endpackage
